//--- xau_pkg.sv
// package with opcodes, widths and counts for the extended arithmetic unit
`default_nettype none
package xau_pkg;
  localparam int WORD_W = 12;
  localparam int CNT_W = 5;
  localparam logic [11:0] OP_MUL = 12'hF05;
  localparam logic [11:0] OP_DIV = 12'hF07;
  localparam logic [11:0] OP_NORM = 12'hF09;
  localparam logic [11:0] OP_SCL = 12'hF03;
  localparam logic [4:0] MUL_END = 5'h0C;
  localparam logic [4:0] DIV_END = 5'h0D;
  localparam logic [4:0] CNT_CLEAR = 5'h00;
  localparam int OPF_LO = 1;
  localparam int OPF_HI = 3;
  localparam int SCL_LO = 0;
  localparam int SCL_HI = 4;
  typedef enum logic [2:0] {XAU_IDLE, XAU_SCL, XAU_MUL, XAU_DIV, XAU_DFIX, XAU_NORM} xau_state_t;
endpackage
`default_nettype wire

//--- xau_adder.sv
// 12-bit adder with carry into the link position
`default_nettype none
module xau_adder #(
  parameter int W = 12
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic cin,
  output logic [W-1:0] sum,
  output logic cout
);
  initial begin
    if (W < 2) $error("xau_adder width too small");
  end
  logic [W:0] full;
  assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
  assign sum = full[W-1:0];
  assign cout = full[W];
endmodule
`default_nettype wire

//--- xau_top.sv
// extended arithmetic unit: multiply, divide, normalize, step counter load
`default_nettype none
// Function
// - multiplier lsb one adds memory operand, zero adds nothing.
// - multiply runs twelve add-shift steps, counter reaching 12 ends timing.
// - product fits 24 bits across primary and multiplier-quotient registers.
// - after each add, link, primary and quotient shift right together.
// - divide opcode divides 24-bit dividend by next memory word.
// - divide step without overflow clears quotient lsb, next step adds.
// - adding phase shifts zero into quotient until overflow returns to subtract.
// - divide ends at count 13, corrects remainder, clears link.
// - quotient lsb chooses keep or one extra add of the operand to the remainder.
// - first subtraction not negative means overflow, exit with link set.
// - normalize shifts both registers left until top two bits differ.
// - normalize leaves shift count in counter, link contents discarded.
// - normalize starts unit timing from fetch, hold set, no execute.
// - normalize first sequence loads opcode field, clears step counter.
// - already normalized value is not shifted.
// - counter load takes complement of low five bits of next word.
// - counter load uses execute cycle without starting unit timing.
// - multiply high product bits in primary, low bits in quotient register.
// - multiply clears counter then increments once per add-shift step.
// - multiply and divide set timing hold until unit finishes.
module xau_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic fetch_strobe,
  input wire logic execute_strobe,
  input wire logic [11:0] memory_buffer,
  input wire logic load_regs,
  input wire logic [11:0] load_primary,
  input wire logic [11:0] load_quotient,
  input wire logic load_link,
  output logic [11:0] primary_register,
  output logic [11:0] multiplier_quotient,
  output logic link,
  output logic [4:0] step_counter,
  output logic [2:0] opcode_field,
  output logic cpu_timing_hold,
  output logic operand_add_enable,
  output logic need_execute,
  output logic done
);
  // ----------------------------------------------------------------
  // state and datapath
  // ----------------------------------------------------------------
  xau_pkg::xau_state_t state;
  logic [11:0] operand;
  logic subtract;
  logic first_step;
  logic [11:0] add_b;
  logic [11:0] sum;
  logic adder_overflow_flag;
  logic add_cin;
  logic is_mul, is_div, is_norm, is_scl;
  logic normalized;
  logic mul_last;
  logic div_last;
  logic rem_negative;
  logic div_top;
  logic div_sign;

  assign is_mul = memory_buffer == xau_pkg::OP_MUL;
  assign is_div = memory_buffer == xau_pkg::OP_DIV;
  assign is_norm = memory_buffer == xau_pkg::OP_NORM;
  assign is_scl = memory_buffer == xau_pkg::OP_SCL;
  // bit 11 is the msb in this numbering
  assign normalized = primary_register[11] != primary_register[10];
  assign mul_last = step_counter == xau_pkg::MUL_END - 5'h01;
  assign div_last = step_counter == xau_pkg::DIV_END - 5'h01;
  assign rem_negative = !multiplier_quotient[0];

  // multiply adds operand or zero; divide adds or subtracts operand
  assign add_b = (state == xau_pkg::XAU_MUL) ? (multiplier_quotient[0] ? operand : 12'h000)
               : (subtract ? ~operand : operand);
  assign add_cin = (state != xau_pkg::XAU_MUL) && subtract;
  // divide steps after the first work on the left-shifted remainder
  logic [11:0] add_a;
  assign add_a = (state == xau_pkg::XAU_DIV && !first_step) ?
                 {primary_register[10:0], multiplier_quotient[11]} : primary_register;
  // thirteenth bit of the shifted remainder, dropped link bit is taken modulo
  assign div_top = (state == xau_pkg::XAU_DIV && !first_step) ? primary_register[11] : 1'b0;
  // sign of the 13-bit result, built from the carry into the link position
  assign div_sign = div_top ^ subtract ^ adder_overflow_flag;

  xau_adder #(.W(12)) u_adder (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sum(sum),
    .cout(adder_overflow_flag)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= xau_pkg::XAU_IDLE;
      primary_register <= 12'h000;
      multiplier_quotient <= 12'h000;
      link <= 1'b0;
      step_counter <= xau_pkg::CNT_CLEAR;
      opcode_field <= 3'h0;
      cpu_timing_hold <= 1'b0;
      operand_add_enable <= 1'b0;
      need_execute <= 1'b0;
      done <= 1'b0;
      operand <= 12'h000;
      subtract <= 1'b1;
      first_step <= 1'b0;
    end else begin
      done <= 1'b0;
      operand_add_enable <= 1'b0;
      case (state)
        xau_pkg::XAU_IDLE: begin
          if (load_regs) begin
            primary_register <= load_primary;
            multiplier_quotient <= load_quotient;
            link <= load_link;
          end else if (fetch_strobe && is_norm) begin
            opcode_field <= memory_buffer[xau_pkg::OPF_HI:xau_pkg::OPF_LO];
            step_counter <= xau_pkg::CNT_CLEAR;
            cpu_timing_hold <= 1'b1;
            link <= 1'b0;
            state <= xau_pkg::XAU_NORM;
          end else if (fetch_strobe && (is_mul || is_div || is_scl)) begin
            opcode_field <= memory_buffer[xau_pkg::OPF_HI:xau_pkg::OPF_LO];
            need_execute <= 1'b1;
            cpu_timing_hold <= !is_scl;
            state <= is_scl ? xau_pkg::XAU_SCL : (is_mul ? xau_pkg::XAU_MUL : xau_pkg::XAU_DIV);
            first_step <= 1'b0;
          end
        end
        xau_pkg::XAU_SCL: begin
          if (execute_strobe) begin
            step_counter <= ~memory_buffer[xau_pkg::SCL_HI:xau_pkg::SCL_LO];
            need_execute <= 1'b0;
            done <= 1'b1;
            state <= xau_pkg::XAU_IDLE;
          end
        end
        xau_pkg::XAU_MUL: begin
          if (!first_step) begin
            if (execute_strobe) begin
              operand <= memory_buffer;
              step_counter <= xau_pkg::CNT_CLEAR;
              link <= 1'b0;
              need_execute <= 1'b0;
              first_step <= 1'b1;
            end
          end else begin
            operand_add_enable <= multiplier_quotient[0];
            {link, primary_register, multiplier_quotient} <=
              {1'b0, adder_overflow_flag, sum, multiplier_quotient[11:1]};
            step_counter <= step_counter + 5'h01;
            if (mul_last) begin
              cpu_timing_hold <= 1'b0;
              done <= 1'b1;
              first_step <= 1'b0;
              state <= xau_pkg::XAU_IDLE;
            end
          end
        end
        xau_pkg::XAU_DIV: begin
          if (!first_step && need_execute) begin
            if (execute_strobe) begin
              operand <= memory_buffer;
              step_counter <= xau_pkg::CNT_CLEAR;
              subtract <= 1'b1;
              need_execute <= 1'b0;
              first_step <= 1'b1;
            end
          end else if (first_step) begin
            // test subtraction must come out negative, else the quotient does not fit
            first_step <= 1'b0;
            if (!div_sign) begin
              link <= 1'b1;
              cpu_timing_hold <= 1'b0;
              done <= 1'b1;
              state <= xau_pkg::XAU_IDLE;
            end else begin
              {link, primary_register} <= {1'b1, sum};
              subtract <= 1'b0;
              step_counter <= step_counter + 5'h01;
            end
          end else begin
            // link and primary register hold the signed partial remainder
            {link, primary_register} <= {div_sign, sum};
            multiplier_quotient <= {multiplier_quotient[10:0], !div_sign};
            subtract <= !div_sign;
            step_counter <= step_counter + 5'h01;
            if (div_last) begin
              state <= xau_pkg::XAU_DFIX;
            end
          end
        end
        xau_pkg::XAU_DFIX: begin
          link <= 1'b0;
          // a negative final remainder leaves quotient lsb 0 and needs one add
          if (rem_negative) begin
            primary_register <= primary_register + operand;
          end
          cpu_timing_hold <= 1'b0;
          done <= 1'b1;
          state <= xau_pkg::XAU_IDLE;
        end
        xau_pkg::XAU_NORM: begin
          if (normalized) begin
            cpu_timing_hold <= 1'b0;
            done <= 1'b1;
            state <= xau_pkg::XAU_IDLE;
          end else begin
            {primary_register, multiplier_quotient} <=
              {primary_register[10:0], multiplier_quotient, 1'b0};
            step_counter <= step_counter + 5'h01;
          end
        end
        default: state <= xau_pkg::XAU_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_fetch_norm;
    state == xau_pkg::XAU_IDLE && !load_regs && fetch_strobe && is_norm;
  endsequence

  sequence s_fetch_mul;
    state == xau_pkg::XAU_IDLE && !load_regs && fetch_strobe && is_mul;
  endsequence

  sequence s_div_step;
    state == xau_pkg::XAU_DIV && !first_step && !need_execute;
  endsequence

  property p_mul_hold;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_MUL && first_step && mul_last) |=> !cpu_timing_hold && done;
  endproperty
  a_mul_hold: assert property (p_mul_hold) else $error("multiply end not released");

  property p_norm_stop;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_NORM && normalized) |=> $stable(primary_register) && done;
  endproperty
  a_norm_stop: assert property (p_norm_stop) else $error("normalized value shifted");

  property p_norm_count;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_NORM && !normalized) |=> step_counter == $past(step_counter) + 5'h01;
  endproperty
  a_norm_count: assert property (p_norm_count) else $error("shift count wrong");

  property p_scl;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_SCL && execute_strobe) |=>
        step_counter == ~$past(memory_buffer[4:0]) && !cpu_timing_hold;
  endproperty
  a_scl: assert property (p_scl) else $error("counter load wrong");

  property p_norm_start;
    @(posedge clk) disable iff (reset)
      s_fetch_norm |=>
        cpu_timing_hold && !need_execute && step_counter == xau_pkg::CNT_CLEAR;
  endproperty
  a_norm_start: assert property (p_norm_start) else $error("normalize start wrong");

  property p_div_ovf;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_DIV && first_step && !div_sign) |=> link && done;
  endproperty
  a_div_ovf: assert property (p_div_ovf) else $error("divide overflow not flagged");

  property p_div_fix;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_DFIX) |=> !link && !cpu_timing_hold;
  endproperty
  a_div_fix: assert property (p_div_fix) else $error("divide end wrong");

  property p_mul_shift;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_MUL && first_step) |=>
        multiplier_quotient[10:0] == $past(multiplier_quotient[11:1]);
  endproperty
  a_mul_shift: assert property (p_mul_shift) else $error("multiply shift wrong");

  property p_mul_start;
    @(posedge clk) disable iff (reset)
      s_fetch_mul |=> cpu_timing_hold && need_execute;
  endproperty
  a_mul_start: assert property (p_mul_start) else $error("multiply start wrong");

  property p_add_enable;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_MUL && first_step) |=>
        operand_add_enable == $past(multiplier_quotient[0]);
  endproperty
  a_add_enable: assert property (p_add_enable) else $error("add enable wrong");

  property p_mul_clear;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_MUL && !first_step && execute_strobe) |=>
        step_counter == xau_pkg::CNT_CLEAR && first_step;
  endproperty
  a_mul_clear: assert property (p_mul_clear) else $error("multiply counter not cleared");

  property p_div_quot;
    @(posedge clk) disable iff (reset)
      s_div_step |=> multiplier_quotient[0] == !$past(div_sign);
  endproperty
  a_div_quot: assert property (p_div_quot) else $error("quotient bit wrong");

  property p_div_next;
    @(posedge clk) disable iff (reset)
      s_div_step |=> subtract == !$past(div_sign);
  endproperty
  a_div_next: assert property (p_div_next) else $error("divide direction wrong");

  property p_div_count;
    @(posedge clk) disable iff (reset)
      s_div_step ##0 div_last |=>
        state == xau_pkg::XAU_DFIX && step_counter == xau_pkg::DIV_END;
  endproperty
  a_div_count: assert property (p_div_count) else $error("divide end count wrong");

  property p_done_pulse;
    @(posedge clk) disable iff (reset)
      done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  property p_scl_free;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_SCL) |-> !cpu_timing_hold;
  endproperty
  a_scl_free: assert property (p_scl_free) else $error("counter load holds timing");

  property p_norm_link;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_NORM) |-> !link;
  endproperty
  a_norm_link: assert property (p_norm_link) else $error("normalize link kept");

  property p_norm_field;
    @(posedge clk) disable iff (reset)
      s_fetch_norm |=>
        opcode_field == $past(memory_buffer[xau_pkg::OPF_HI:xau_pkg::OPF_LO]);
  endproperty
  a_norm_field: assert property (p_norm_field) else $error("opcode field wrong");

  property p_hold_busy;
    @(posedge clk) disable iff (reset)
      (state == xau_pkg::XAU_MUL || state == xau_pkg::XAU_DIV ||
       state == xau_pkg::XAU_DFIX || state == xau_pkg::XAU_NORM) |-> cpu_timing_hold;
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("timing hold dropped early");
endmodule
`default_nettype wire

//--- xau_cpu_model.sv
// processor fetch/execute timing model that feeds the unit
`default_nettype none
module xau_cpu_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [11:0] instr,
  input wire logic [11:0] operand,
  input wire logic need_execute,
  output logic fetch_strobe,
  output logic execute_strobe,
  output logic [11:0] memory_buffer
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    fetch_strobe = 1'b0;
    execute_strobe = 1'b0;
    memory_buffer = 12'h000;
  end
  // released buffer shows the inverse of the last word, never a stale copy
  always begin
    wait (go === 1'b1);
    @(negedge clk);
    fetch_strobe = 1'b1;
    memory_buffer = instr;
    @(negedge clk);
    fetch_strobe = 1'b0;
    memory_buffer = ~instr;
    // execute only when the unit asks for it
    if (need_execute === 1'b1) begin
      execute_strobe = 1'b1;
      memory_buffer = operand;
      @(negedge clk);
      execute_strobe = 1'b0;
      memory_buffer = ~operand;
    end
    wait (go === 1'b0);
  end
endmodule
`default_nettype wire

//--- tb_extended_arith_mul_div_norm.sv
// self-checking bench for the extended arithmetic unit
`default_nettype none
module tb_extended_arith_mul_div_norm;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, go = 0, load_regs = 0, load_link = 0;
  logic [11:0] instr = 0, operand = 0, load_primary = 0, load_quotient = 0, mem_word, prim, mqt;
  logic fs, es, lk, hold, add_en, need_ex, done;
  logic [4:0] cnt;
  logic [2:0] opf;
  int n_fail = 0, cmp_count = 0, adds, held, exed, cyc;
  always #25 clk = ~clk;
  xau_cpu_model u_cpu (.clk(clk), .go(go), .instr(instr), .operand(operand),
    .need_execute(need_ex), .fetch_strobe(fs), .execute_strobe(es), .memory_buffer(mem_word));
  xau_top u_dut (.clk(clk), .reset(reset), .fetch_strobe(fs), .execute_strobe(es),
    .memory_buffer(mem_word), .load_regs(load_regs), .load_primary(load_primary),
    .load_quotient(load_quotient),
    .load_link(load_link), .primary_register(prim), .multiplier_quotient(mqt), .link(lk),
    .step_counter(cnt), .opcode_field(opf), .cpu_timing_hold(hold),
    .operand_add_enable(add_en), .need_execute(need_ex), .done(done));
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task load(input logic [11:0] p, input logic [11:0] q, input logic l);
    @(negedge clk);
    load_primary = p;
    load_quotient = q;
    load_link = l;
    load_regs = 1;
    @(negedge clk);
    load_regs = 0;
  endtask
  task run(input logic [11:0] i, input logic [11:0] d);
    adds = 0; held = 0; exed = 0; cyc = 0;
    @(negedge clk);
    instr = i;
    operand = d;
    go = 1;
    while (done !== 1'b1 && cyc < 200) begin
      @(posedge clk);
      #1;
      cyc++;
      adds += int'(add_en === 1'b1);
      held |= int'(hold === 1'b1);
      exed |= int'(es === 1'b1);
    end
    chk("done", 1, done);
    @(negedge clk);
    go = 0;
    chk("hold_off", 0, hold);
  endtask
  logic [11:0] m1[4] = '{12'hFFF, 12'h00C, 12'h000, 12'h800};
  logic [11:0] m2[4] = '{12'hFFF, 12'h00C, 12'h5A5, 12'h001};
  logic [11:0] da[5] = '{12'h000, 12'h005, 12'h000, 12'h00C, 12'h123};
  logic [11:0] dq[5] = '{12'h091, 12'h678, 12'hFFF, 12'h000, 12'h000};
  logic [11:0] dd[5] = '{12'h00C, 12'h9AB, 12'h001, 12'h00C, 12'h000};
  logic [23:0] nv[4] = '{24'h400123, 24'h001000, 24'h000001, 24'hFFE000};
  int ns[4] = '{0, 10, 22, 10};
  initial begin
    repeat (4) @(posedge clk);
    chk("reset", 0, {prim, mqt}); // see RESET
    chk("reset_flags", 0, {lk, cnt, opf, hold, add_en, need_ex, done}); // see RESET
    @(negedge clk);
    reset = 0;
    for (int i = 0; i < 4; i++) begin
      load(12'h000, m1[i], 1'b0);
      run(xau_pkg::OP_MUL, m2[i]);
      chk("product", m1[i] * m2[i], {prim, mqt});
      chk("mul_steps", 24'(xau_pkg::MUL_END), cnt);
      chk("mul_adds", $countones(m1[i]), adds);
      chk("mul_hold", 1, held);
    end
    for (int i = 0; i < 5; i++) begin
      load(da[i], dq[i], 1'b0);
      run(xau_pkg::OP_DIV, dd[i]);
      if (i < 3) begin
        chk("quotient", {da[i], dq[i]} / dd[i], mqt);
        chk("remainder", {da[i], dq[i]} % dd[i], prim);
        chk("div_link", 0, lk);
      end else begin
        chk("ovf_link", 1, lk);
        chk("ovf_fast", 1, cyc <= 4);
      end
      chk("div_hold", 1, held);
    end
    for (int i = 0; i < 4; i++) begin
      load(nv[i][23:12], nv[i][11:0], 1'b1);
      run(xau_pkg::OP_NORM, 12'h000);
      chk("norm_value", nv[i] << ns[i], {prim, mqt});
      chk("norm_count", ns[i], cnt);
      chk("norm_field", xau_pkg::OP_NORM[3:1], opf);
      chk("norm_no_exec", 0, exed);
    end
    run(xau_pkg::OP_SCL, 12'h000);
    chk("scl_zero", 24'h1F, cnt);
    run(xau_pkg::OP_SCL, 12'hFFE);
    chk("scl_ones", 24'h01, cnt);
    chk("scl_exec", 1, exed);
    chk("scl_hold", 0, held);
    end_sim;
  end
  initial begin
    #200us;
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire
